// ==== core/cache_maint_consts.vh ====
// Constants for the cache-maintenance engine: instruction fields, operation codes,
// register offsets, holder field positions and cache geometry.
// Assumes inclusion by bare name from a Verilog-2005 design file.
`ifndef CACHE_MAINT_CONSTS_VH
`define CACHE_MAINT_CONSTS_VH

`define MAJOR_OPC 6'h2f
`define F_OPC_HI 31
`define F_OPC_LO 26
`define F_BASE_HI 25
`define F_BASE_LO 21
`define F_OP_HI 20
`define F_OP_LO 18
`define F_SEL_HI 17
`define F_SEL_LO 16
`define F_OFF_HI 15
`define F_OFF_LO 0

`define SIZE_LOG2 10
`define LINE_SIZE_LOG2 4
`define DWORD_BIT 3

`define SEL_ICACHE 2'h0
`define SEL_DCACHE 2'h1

`define OP_IDX_INVAL 3'h0
`define OP_LOAD_TAG 3'h1
`define OP_STORE_TAG 3'h2
`define OP_CREATE_DIRTY 3'h3
`define OP_HIT_INVAL 3'h4
`define OP_HIT_WBINV_FILL 3'h5
`define OP_HIT_WB 3'h6

`define EXC_NONE 3'h0
`define EXC_COP_UNUSABLE 3'h1
`define EXC_TLB_REFILL 3'h2
`define EXC_TLB_INVALID 3'h3
`define EXC_RESERVED_INSTR 3'h4

`define MODE_KERNEL 2'h0

`define REG_INSTR 8'h00
`define REG_BASE_VAL 8'h04
`define REG_STATUS 8'h08
`define REG_CTRL 8'h0c
`define REG_RESULT 8'h10
`define REG_LOWER_TAG 8'h14
`define REG_UPPER_TAG 8'h18
`define REG_PARITY 8'h1c
`define REG_VLOC 8'h20
`define REG_PLOC 8'h24

`define ST_CP0_EN 0
`define ST_MODE_LO 1
`define ST_MODE_HI 2
`define ST_CE 3

`define LT_TAG_LO 10
`define LT_VALID 7
`define LT_DIRTY 6

`endif

// ==== core/cache_maint_ops.v ====
// Cache-maintenance engine for the primary instruction and data caches, with its own
// tag, state, data and parity arrays and an APB register port.
// Assumes a single-cycle-answer-free TLB port and a word memory port on pclk.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cache_maint_consts.vh"

// Behaviour
// - Decode major opcode 101111, base, sub-function and 16-bit offset fields.
// - Virtual location is base register value plus sign-extended offset.
// - Translate through the TLB, then apply the selected operation.
// - User or supervisor mode without coprocessor enable raises coprocessor-unusable.
// - Index operations pick the block from virtual bits size minus one down to line.
// - Tag read picks doubleword parity from virtual bits line minus one down to three.
// - Hit operations act only on a valid block whose tag matches, except code 5 on instruction cache, which fills on hit or miss.
// - Write-back goes to the address held in the block's tag.
// - TLB refill or invalid may be raised; never TLB modified.
// - Bits 17..16 select instruction cache, data cache, or reserved.
// - Bits 20..18 give the operation code, read with the selector.
// - Code 0 on instruction cache invalidates the indexed block.
// - Code 0 on data cache writes back valid dirty block, then invalidates.
// - Code 1 loads tag into lower holder and parity into parity register.
// - Code 2 writes the block tag from the lower and upper holders.
// - Code 3 data: write back dirty non-matching block, then mark dirty.
// - Code 4 invalidates the block when it holds the address.
// - Code 5 data: on hit write back if dirty, then invalidate.
// - Code 5 instruction fills from memory; override parity of the addressed doubleword when enabled.
// - Code 6 instruction: on hit write back data unconditionally.
module cache_maint_ops (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg tlb_req,
  output reg [31:0] tlb_virtual_location,
  input wire tlb_ack,
  input wire [31:0] tlb_paddr,
  input wire tlb_refill,
  input wire tlb_invalid,
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  output wire [4:0] base_sel,
  output wire busy,
  output reg op_done,
  output reg [2:0] exc_code
);

  localparam IDLE = 3'h0;
  localparam XLATE = 3'h1;
  localparam LOOK = 3'h2;
  localparam WB = 3'h3;
  localparam FILL = 3'h4;
  localparam FIN = 3'h5;

  reg [2:0] st_q;
  reg [31:0] instr_q;
  reg [31:0] base_val_q;
  reg [3:0] status_q;
  reg [31:0] vloc_q;
  reg [31:0] ploc_q;
  reg [31:0] lower_tag_holder_q;
  reg [31:0] upper_tag_holder_q;
  reg [7:0] parity_fault_reg_q;
  reg hit_q;
  reg [1:0] word_q;
  reg [127:0] valid_q;
  reg [127:0] dirty_q;

  reg [21:0] tag_mem [0:127];
  reg tag_par_mem [0:127];
  reg [31:0] data_mem [0:511];
  reg [7:0] par_mem [0:255];

  // Byte parity over one doubleword.
  function [7:0] byte_par;
    input [63:0] dw;
    integer b;
    begin
      byte_par = 8'h00;
      for (b = 0; b < 8; b = b + 1)
        byte_par[b] = ^dw[b*8 +: 8];
    end
  endfunction

  // Opcode and selector tests, used by the lookup and by the final update.
  function is_op;
    input [1:0] sel;
    input [2:0] op;
    input [1:0] want_sel;
    input [2:0] want_op;
    begin
      is_op = (sel == want_sel) && (op == want_op);
    end
  endfunction

  wire [5:0] major_opc = instr_q[`F_OPC_HI:`F_OPC_LO];
  wire [2:0] op_code = instr_q[`F_OP_HI:`F_OP_LO];
  wire [1:0] cache_sel = instr_q[`F_SEL_HI:`F_SEL_LO];
  wire [15:0] offset = instr_q[`F_OFF_HI:`F_OFF_LO];
  wire [31:0] vloc_d = base_val_q + {{16{offset[15]}}, offset};
  wire is_d = (cache_sel == `SEL_DCACHE);
  wire [1:0] mode = status_q[`ST_MODE_HI:`ST_MODE_LO];

  // Index from virtual bits size_log2-1 down to line_size_log2, cache bit on top.
  wire [6:0] ent = {cache_sel[0], vloc_q[`SIZE_LOG2-1:`LINE_SIZE_LOG2]};
  wire [21:0] cur_tag = tag_mem[ent];
  wire cur_valid = valid_q[ent];
  wire cur_dirty = dirty_q[ent];
  wire hit = cur_valid && (cur_tag == ploc_q[31:`SIZE_LOG2]);
  wire [31:0] wb_base = {cur_tag, ent[5:0], 4'h0};

  wire need_wb =
    (is_op(cache_sel, op_code, `SEL_DCACHE, `OP_IDX_INVAL) && cur_valid && cur_dirty) ||
    (is_op(cache_sel, op_code, `SEL_DCACHE, `OP_CREATE_DIRTY) && !hit && cur_valid && cur_dirty) ||
    (is_op(cache_sel, op_code, `SEL_DCACHE, `OP_HIT_WBINV_FILL) && hit && cur_dirty) ||
    (is_op(cache_sel, op_code, `SEL_DCACHE, `OP_HIT_WB) && hit && cur_dirty) ||
    (is_op(cache_sel, op_code, `SEL_ICACHE, `OP_HIT_WB) && hit);
  wire need_fill = is_op(cache_sel, op_code, `SEL_ICACHE, `OP_HIT_WBINV_FILL);

  wire fin = (st_q == FIN);
  wire store_tag = fin && (op_code == `OP_STORE_TAG);
  wire new_tag = fin && (is_op(cache_sel, op_code, `SEL_DCACHE, `OP_CREATE_DIRTY) || need_fill);
  wire fill_take = (st_q == FILL) && mem_ack;
  wire [8:0] word_idx = {ent, word_q};
  wire odd_word = word_q[0];
  wire [7:0] fill_par = (status_q[`ST_CE] && (word_q[1] == vloc_q[`DWORD_BIT])) ?
    parity_fault_reg_q : byte_par({mem_rdata, data_mem[{ent, word_q[1], 1'b0}]});

  wire apb_wr = psel && penable && pwrite;
  wire mapped = (paddr == `REG_INSTR) || (paddr == `REG_BASE_VAL) || (paddr == `REG_STATUS) ||
    (paddr == `REG_CTRL) || (paddr == `REG_RESULT) || (paddr == `REG_LOWER_TAG) ||
    (paddr == `REG_UPPER_TAG) || (paddr == `REG_PARITY) || (paddr == `REG_VLOC) ||
    (paddr == `REG_PLOC);
  wire start = apb_wr && (paddr == `REG_CTRL) && pwdata[0] && (st_q == IDLE);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign busy = (st_q != IDLE);
  assign base_sel = instr_q[`F_BASE_HI:`F_BASE_LO];

  // Array contents carry no reset; the valid vectors guard them.
  always @(posedge pclk)
  begin
    if (store_tag)
    begin
      tag_mem[ent] <= lower_tag_holder_q[31:`LT_TAG_LO];
      tag_par_mem[ent] <= upper_tag_holder_q[0];
    end
    else if (new_tag)
    begin
      tag_mem[ent] <= ploc_q[31:`SIZE_LOG2];
      tag_par_mem[ent] <= ^ploc_q[31:`SIZE_LOG2];
    end
    if (fill_take)
    begin
      data_mem[word_idx] <= mem_rdata;
      if (odd_word)
        par_mem[{ent, word_q[1]}] <= fill_par;
    end
  end

  always @*
  begin
    case (paddr)
      `REG_INSTR: prdata = instr_q;
      `REG_BASE_VAL: prdata = base_val_q;
      `REG_STATUS: prdata = {28'h0000000, status_q};
      `REG_RESULT: prdata = {27'h0000000, exc_code, hit_q, busy};
      `REG_LOWER_TAG: prdata = lower_tag_holder_q;
      `REG_UPPER_TAG: prdata = upper_tag_holder_q;
      `REG_PARITY: prdata = {24'h000000, parity_fault_reg_q};
      `REG_VLOC: prdata = vloc_q;
      `REG_PLOC: prdata = ploc_q;
      default: prdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= IDLE;
      instr_q <= 32'h00000000;
      base_val_q <= 32'h00000000;
      status_q <= 4'h0;
      vloc_q <= 32'h00000000;
      ploc_q <= 32'h00000000;
      lower_tag_holder_q <= 32'h00000000;
      upper_tag_holder_q <= 32'h00000000;
      parity_fault_reg_q <= 8'h00;
      hit_q <= 1'b0;
      word_q <= 2'h0;
      valid_q <= 128'h0;
      dirty_q <= 128'h0;
      tlb_req <= 1'b0;
      tlb_virtual_location <= 32'h00000000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      op_done <= 1'b0;
      exc_code <= `EXC_NONE;
    end
    else
    begin
      op_done <= 1'b0;
      if (apb_wr && (st_q == IDLE))
      begin
        case (paddr)
          `REG_INSTR: instr_q <= pwdata;
          `REG_BASE_VAL: base_val_q <= pwdata;
          `REG_LOWER_TAG: lower_tag_holder_q <= pwdata;
          `REG_UPPER_TAG: upper_tag_holder_q <= pwdata;
          `REG_PARITY: parity_fault_reg_q <= pwdata[7:0];
          default: ;
        endcase
      end
      if (apb_wr && (paddr == `REG_STATUS))
        status_q <= pwdata[3:0];
      case (st_q)
        IDLE:
        begin
          if (start)
          begin
            exc_code <= `EXC_NONE;
            hit_q <= 1'b0;
            if (major_opc != `MAJOR_OPC)
            begin
              exc_code <= `EXC_RESERVED_INSTR;
              op_done <= 1'b1;
            end
            else if ((mode != `MODE_KERNEL) && !status_q[`ST_CP0_EN])
            begin
              exc_code <= `EXC_COP_UNUSABLE;
              op_done <= 1'b1;
            end
            else
            begin
              vloc_q <= vloc_d;
              tlb_virtual_location <= vloc_d;
              tlb_req <= 1'b1;
              st_q <= XLATE;
            end
          end
        end
        XLATE:
        begin
          if (tlb_ack)
          begin
            tlb_req <= 1'b0;
            // Only refill and invalid are reported; no modified fault exists here.
            if (tlb_refill)
            begin
              exc_code <= `EXC_TLB_REFILL;
              op_done <= 1'b1;
              st_q <= IDLE;
            end
            else if (tlb_invalid)
            begin
              exc_code <= `EXC_TLB_INVALID;
              op_done <= 1'b1;
              st_q <= IDLE;
            end
            else
            begin
              ploc_q <= tlb_paddr;
              // Reserved selectors complete with no effect.
              if (cache_sel[1])
              begin
                op_done <= 1'b1;
                st_q <= IDLE;
              end
              else
                st_q <= LOOK;
            end
          end
        end
        LOOK:
        begin
          hit_q <= hit;
          word_q <= 2'h0;
          if (need_wb)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= wb_base;
            mem_wdata <= data_mem[{ent, 2'h0}];
            st_q <= WB;
          end
          else if (need_fill)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= {ploc_q[31:`LINE_SIZE_LOG2], 4'h0};
            st_q <= FILL;
          end
          else
            st_q <= FIN;
        end
        WB, FILL:
        begin
          if (mem_ack)
          begin
            if (word_q == 2'h3)
            begin
              mem_req <= 1'b0;
              mem_we <= 1'b0;
              st_q <= FIN;
            end
            else
            begin
              word_q <= word_q + 2'h1;
              mem_addr <= {mem_addr[31:`LINE_SIZE_LOG2], word_q + 2'h1, 2'h0};
              mem_wdata <= data_mem[{ent, word_q + 2'h1}];
            end
          end
        end
        FIN:
        begin
          op_done <= 1'b1;
          st_q <= IDLE;
          case (op_code)
            `OP_IDX_INVAL:
            begin
              valid_q[ent] <= 1'b0;
              dirty_q[ent] <= 1'b0;
            end
            `OP_LOAD_TAG:
            begin
              lower_tag_holder_q <= {cur_tag, 2'h0, cur_valid, cur_dirty, 6'h00};
              upper_tag_holder_q <= {31'h00000000, tag_par_mem[ent]};
              parity_fault_reg_q <= par_mem[{ent, vloc_q[`DWORD_BIT]}];
            end
            `OP_STORE_TAG:
            begin
              valid_q[ent] <= lower_tag_holder_q[`LT_VALID];
              dirty_q[ent] <= lower_tag_holder_q[`LT_DIRTY] && is_d;
            end
            `OP_CREATE_DIRTY:
            begin
              if (is_d)
              begin
                valid_q[ent] <= 1'b1;
                dirty_q[ent] <= 1'b1;
              end
            end
            `OP_HIT_INVAL:
            begin
              if (hit_q)
              begin
                valid_q[ent] <= 1'b0;
                dirty_q[ent] <= 1'b0;
              end
            end
            `OP_HIT_WBINV_FILL:
            begin
              if (is_d && hit_q)
              begin
                valid_q[ent] <= 1'b0;
                dirty_q[ent] <= 1'b0;
              end
              else if (!is_d)
                valid_q[ent] <= 1'b1;
            end
            `OP_HIT_WB:
            begin
              if (is_d && hit_q)
                dirty_q[ent] <= 1'b0;
            end
            default: ;
          endcase
        end
        default: st_q <= IDLE;
      endcase
    end
  end

endmodule // cache_maint_ops

`default_nettype wire

// ==== bench/cache_maint_ops_props.sv ====
// Checker for the cache-maintenance engine: start, completion and handshake holding.
// Assumes it is bound to the engine, all inputs being engine ports of the same name.
`timescale 1ns/100ps
`default_nettype none
module cache_maint_ops_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic tlb_req,
  input wire logic [31:0] tlb_virtual_location,
  input wire logic tlb_ack,
  input wire logic tlb_refill,
  input wire logic tlb_invalid,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic busy,
  input wire logic op_done,
  input wire logic [2:0] exc_code
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A start either runs the engine or is refused at once with a completion pulse.
  start_goes_busy_a: assert property (psel && penable && pwrite && paddr == 8'h0c && pwdata[0] && !busy |=> busy != op_done)
    else $error("start not taken");
  done_pulse_a: assert property (op_done |=> !op_done)
    else $error("completion longer than one cycle");
  done_idle_a: assert property (op_done |-> !busy)
    else $error("busy at completion");
  tlb_hold_a: assert property (tlb_req && !tlb_ack |=> tlb_req && $stable(tlb_virtual_location))
    else $error("translation request dropped");
  refill_report_a: assert property (tlb_req && tlb_ack && tlb_refill |-> ##[1:2] (op_done && exc_code == 3'h2))
    else $error("refill not reported");
  exc_range_a: assert property (op_done |-> exc_code <= 3'h4)
    else $error("unknown exception code");
  xlate_clean_a: assert property (tlb_req && tlb_ack && !tlb_refill && !tlb_invalid |=> exc_code == 3'h0)
    else $error("exception after clean translation");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed");
  line_base_a: assert property ($rose(mem_req) |-> mem_addr[3:0] == 4'h0)
    else $error("burst not at line base");
endmodule // cache_maint_ops_props
bind cache_maint_ops cache_maint_ops_props cache_maint_ops_props_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .tlb_req, .tlb_virtual_location, .tlb_ack, .tlb_refill, .tlb_invalid, .mem_req, .mem_we, .mem_addr, .mem_ack, .busy,
  .op_done, .exc_code);
`default_nettype wire

// ==== bench/far_side_model.sv ====
// Far-side model: translation unit and memory answering the engine, promptly or slowly.
// Assumes the engine's clock; counts write-back words and keeps the last address.
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic tlb_req,
  input wire logic [31:0] tlb_virtual_location,
  output logic tlb_ack,
  output logic [31:0] tlb_paddr,
  output logic tlb_refill,
  output logic tlb_invalid,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic [7:0] wr_count,
  output logic [31:0] last_wr,
  output logic [31:0] last_wdata
);
  logic [1:0] wait_q;
  // Outside an answer the address and data lines carry inverted values and both fault lines are high, so stale data never matches.
  assign tlb_paddr = tlb_ack ? tlb_virtual_location : ~tlb_virtual_location;
  assign tlb_refill = tlb_ack ? tlb_virtual_location[31:28] == 4'hf : 1'b1;
  assign tlb_invalid = tlb_ack ? tlb_virtual_location[31:28] == 4'he : 1'b1;
  assign mem_rdata = mem_ack ? mem_addr ^ 32'h5a5a0000 : ~mem_addr;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tlb_ack <= 1'b0;
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      wr_count <= 8'h0;
      last_wr <= 32'h0;
      last_wdata <= 32'h0;
    end
    else
    begin
      tlb_ack <= 1'b0;
      mem_ack <= 1'b0;
      if ((tlb_req || mem_req) && !tlb_ack && !mem_ack)
      begin
        wait_q <= wait_q + 2'h1;
        if (!slow || wait_q == 2'h2)
        begin
          tlb_ack <= tlb_req;
          mem_ack <= mem_req;
          wait_q <= 2'h0;
        end
      end
      if (mem_ack && mem_req && mem_we)
      begin
        wr_count <= wr_count + 8'h1;
        last_wr <= mem_addr;
        last_wdata <= mem_wdata;
      end
    end
  end
endmodule // far_side_model
`default_nettype wire

// ==== bench/cache_maint_ops_tb.sv ====
// Bench for the cache-maintenance engine: exception table, then cache state sequences.
// Assumes the engine, its checker and the far-side model are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module cache_maint_ops_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, err, busy, op_done;
  logic tlb_req, tlb_ack, tlb_refill, tlb_invalid, mem_req, mem_we, mem_ack;
  logic [7:0] paddr, wr_count;
  logic [31:0] pwdata, prdata, rd, tlb_virtual_location, tlb_paddr, mem_addr, mem_wdata, mem_rdata, last_wr, last_wdata;
  logic [4:0] base_sel;
  logic [2:0] exc_code;
  int miscompares, compares;
  localparam logic [31:0] V = 32'h00012340;
  localparam logic [31:0] W = 32'h00056340;
  typedef struct {logic [31:0] i; logic [31:0] b; logic [3:0] st; logic [2:0] ex;} row_t;
  row_t rows[6];
  cache_maint_ops cache_maint_ops_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tlb_req, .tlb_virtual_location, .tlb_ack, .tlb_paddr, .tlb_refill, .tlb_invalid, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .base_sel, .busy, .op_done, .exc_code);
  far_side_model far_side_model_i (.pclk, .presetn, .slow, .tlb_req, .tlb_virtual_location, .tlb_ack, .tlb_paddr,
    .tlb_refill, .tlb_invalid, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .wr_count, .last_wr,
    .last_wdata);
  function automatic logic [31:0] ins(input logic [2:0] op, input logic [1:0] sel, input logic [15:0] off);
    return {6'h2f, 5'h03, op, sel, off};
  endfunction
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hung();
    miscompares++;
    report_and_stop();
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50)
      hung();
  endtask
  task automatic run(input logic [31:0] i, input logic [31:0] b);
    int n;
    n = 0;
    apb(1'b1, 8'h00, i);
    apb(1'b1, 8'h04, b);
    apb(1'b1, 8'h0c, 32'h1);
    while (busy !== 1'b0 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300)
      hung();
  endtask
  task automatic store_tag(input logic [31:0] lo);
    apb(1'b1, 8'h14, lo);
    apb(1'b1, 8'h18, 32'h0);
    run(ins(3'h2, 2'h1, 16'h0), V);
  endtask
  task automatic load_tag(input logic [1:0] sel);
    run(ins(3'h1, sel, 16'h0), V);
    apb(1'b0, 8'h14, 32'h0);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    chk("result after reset", rd, 32'h0);
    rows = '{'{{6'h2e, 26'h0}, 32'h100, 4'h0, 3'h4}, '{ins(3'h0, 2'h0, 16'h0), 32'h100, 4'h4, 3'h1},
      '{ins(3'h0, 2'h1, 16'h0), 32'h100, 4'h2, 3'h1}, '{ins(3'h0, 2'h0, 16'h0), 32'h100, 4'h5, 3'h0},
      '{ins(3'h4, 2'h1, 16'h0), 32'hf0000100, 4'h0, 3'h2}, '{ins(3'h4, 2'h0, 16'h0), 32'he0000100, 4'h0, 3'h3}};
    foreach (rows[k])
    begin
      apb(1'b1, 8'h08, {28'h0, rows[k].st});
      run(rows[k].i, rows[k].b);
      apb(1'b0, 8'h10, 32'h0);
      chk("exception code", {29'h0, rd[4:2]}, {29'h0, rows[k].ex});
    end
    apb(1'b1, 8'h08, 32'h0);
    run(ins(3'h4, 2'h1, 16'hfff0), 32'h00001000);
    apb(1'b0, 8'h20, 32'h0);
    chk("virtual location", rd, 32'h00000ff0);
    chk("base select", {27'h0, base_sel}, 32'h3);
    slow <= 1'b1;
    store_tag(32'h000120c0);
    run(ins(3'h0, 2'h1, 16'h0), W);
    chk("write count", {24'h0, wr_count}, 32'h4);
    chk("write address", last_wr, 32'h0001234c);
    load_tag(2'h1);
    chk("state after flush", {30'h0, rd[7:6]}, 32'h0);
    store_tag(32'h000120c0);
    run(ins(3'h6, 2'h1, 16'h0), W);
    chk("miss writes", {24'h0, wr_count}, 32'h4);
    run(ins(3'h6, 2'h1, 16'h0), V);
    load_tag(2'h1);
    chk("hit writes", {24'h0, wr_count}, 32'h8);
    chk("tag after clean", rd & 32'hfffffcc0, 32'h00012080);
    run(ins(3'h4, 2'h1, 16'h0), V);
    load_tag(2'h1);
    chk("hit invalidate", {31'h0, rd[7]}, 32'h0);
    run(ins(3'h3, 2'h1, 16'h0), V);
    load_tag(2'h1);
    chk("create dirty", rd & 32'hfffffcc0, 32'h000120c0);
    run(ins(3'h5, 2'h1, 16'h0), V);
    load_tag(2'h1);
    chk("flush writes", {24'h0, wr_count}, 32'hc);
    chk("flush state", {31'h0, rd[7]}, 32'h0);
    apb(1'b1, 8'h1c, 32'ha5);
    apb(1'b1, 8'h08, 32'h8);
    run(ins(3'h5, 2'h0, 16'h0), V);
    run(ins(3'h1, 2'h0, 16'h0), V);
    apb(1'b0, 8'h1c, 32'h0);
    chk("override parity", rd, 32'ha5);
    run(ins(3'h1, 2'h0, 16'h8), V);
    apb(1'b0, 8'h1c, 32'h0);
    chk("computed parity", rd, 32'h76);
    run(ins(3'h6, 2'h0, 16'h0), V);
    chk("fill then write back", {24'h0, wr_count}, 32'h10);
    chk("write-back data", last_wdata, 32'h5a5b234c);
    apb(1'b0, 8'h10, 32'h0);
    chk("hit flag", {31'h0, rd[1]}, 32'h1);
    run(ins(3'h0, 2'h0, 16'h0), V);
    load_tag(2'h0);
    chk("index invalidate", {31'h0, rd[7]}, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    report_and_stop();
  end
endmodule // cache_maint_ops_tb
`default_nettype wire
